// >>> design/adcc_pkg.sv
// Package for the converter control block: register map, fields and timing
package adcc_pkg;
   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] OFF_START = 12'h000;
   localparam logic [11:0] OFF_STOP = 12'h004;
   localparam logic [11:0] OFF_DONE = 12'h100;
   localparam logic [11:0] OFF_INTERRUPT_ENABLE = 12'h300;
   localparam logic [11:0] OFF_INTSET = 12'h304;
   localparam logic [11:0] OFF_INTCLR = 12'h308;
   localparam logic [11:0] OFF_BUSY = 12'h400;
   localparam logic [11:0] OFF_ENABLE = 12'h500;
   localparam logic [11:0] OFF_CONFIG = 12'h504;
   localparam logic [11:0] OFF_RESULT = 12'h508;
   localparam int ADDR_W = 12;

   // ----------------------------------------------------------------
   // Configuration field layout and reset value
   // ----------------------------------------------------------------
   localparam int RES_LSB = 0;
   localparam int INPSEL_LSB = 2;
   localparam int REFSEL_LSB = 5;
   localparam int PSEL_LSB = 8;
   localparam int EXTREF_LSB = 16;
   localparam logic [31:0] CONFIG_MASK = 32'h0003_ff7f;
   localparam logic [31:0] CONFIG_RESET = 32'h0000_0018;
   localparam logic [1:0] RES_8BIT = 2'h0;
   localparam logic [1:0] RES_9BIT = 2'h1;
   localparam logic [1:0] RES_10BIT = 2'h2;
   localparam int RESULT_W = 10;

   // ----------------------------------------------------------------
   // Conversion timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 25;
   localparam int CONV8_US = 20;
   localparam int CONV10_US = 68;
   localparam int CONV8_CYC = CONV8_US * CLK_MHZ;
   localparam int CONV10_CYC = CONV10_US * CLK_MHZ;
   localparam int CONV9_CYC = (CONV8_CYC + CONV10_CYC) / 2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] res;
      logic [2:0] inpsel;
      logic [1:0] refsel;
      logic [7:0] psel;
      logic [1:0] extref;
   } adcc_cfg_t;

   typedef enum logic [1:0] {
      ADCC_OFF,
      ADCC_CONVERT,
      ADCC_STORE
   } adcc_state_t;
endpackage

// >>> design/adcc_top.sv
// Converter control block: AHB-Lite registers, one-shot sequencer, result store
//
// Notes on behaviour
// - A conversion starts on a start task write or an event fabric trigger pulse.
// - Busy reads 1 while converting, 0 when idle.
// - Completion pulses the done event and loads the result register.
// - Analog circuitry is powered down after each conversion until next start.
// - One conversion per start; the sequencer never restarts itself.
// - Input, reference, resolution and prescaling come from the configuration register.
// - Enable set claims the selected analog input pin; clear disables converter.
// - Pin select chooses one of eight analog input pins, zero to seven.
// - Samples above full scale produce the maximum code.
// - Interrupt enable bit 0 gates the sticky done flag onto the interrupt.
// - Writing 0 to set or clear has no effect; reads return enable.
// - Result holds the latest completed conversion and is read only.
// - Result refreshes on every completed conversion, not on a stopped or disabled one, right justified at bit 0.
//
// The AHB-Lite slave port is this design's own decision.
module adcc_top #(
   parameter int SAMPLE_W = 12,
   parameter int CONV8_CYCLES = adcc_pkg::CONV8_CYC,
   parameter int CONV9_CYCLES = adcc_pkg::CONV9_CYC,
   parameter int CONV10_CYCLES = adcc_pkg::CONV10_CYC
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // AHB-Lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // Event fabric
   input wire logic i_start_trig,
   input wire logic i_stop_trig,
   output logic o_done_event,
   output logic o_irq,
   // Analog front end
   input wire logic [SAMPLE_W-1:0] i_sample,
   output logic o_analog_power,
   output logic o_pin_claim,
   output logic [2:0] o_pin_index,
   output adcc_pkg::adcc_cfg_t o_cfg
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [SAMPLE_W-1:0] sample_s1;
   logic [SAMPLE_W-1:0] sample_s2;
   logic dp_wr;
   logic dp_rd;
   logic [adcc_pkg::ADDR_W-1:0] dp_addr;
   logic wr_start;
   logic wr_stop;
   logic wr_done;
   logic wr_interrupt_enable;
   logic wr_intset;
   logic wr_intclr;
   logic wr_enable;
   logic wr_config;
   logic interrupt_enable;
   logic done_flag;
   logic enable;
   logic [31:0] config_q;
   logic [adcc_pkg::RESULT_W-1:0] result;
   adcc_pkg::adcc_state_t state;
   logic [15:0] count;
   logic [15:0] conv_len;
   logic start_req;
   logic stop_req;
   logic finish;
   logic [adcc_pkg::RESULT_W-1:0] next_result;
   logic pin_valid;
   logic [2:0] pin_enc;

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   // Address phase capture; zero wait states
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         dp_wr <= 1'b0;
         dp_rd <= 1'b0;
         dp_addr <= '0;
      end else if (i_hready) begin
         dp_wr <= i_hsel && i_htrans[1] && i_hwrite;
         dp_rd <= i_hsel && i_htrans[1] && !i_hwrite;
         dp_addr <= i_haddr[adcc_pkg::ADDR_W-1:0];
      end
   end

   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;

   // Data phase write decode
   assign wr_start = dp_wr && dp_addr == adcc_pkg::OFF_START && i_hwdata[0];
   assign wr_stop = dp_wr && dp_addr == adcc_pkg::OFF_STOP && i_hwdata[0];
   assign wr_done = dp_wr && dp_addr == adcc_pkg::OFF_DONE;
   assign wr_interrupt_enable = dp_wr && dp_addr == adcc_pkg::OFF_INTERRUPT_ENABLE;
   assign wr_intset = dp_wr && dp_addr == adcc_pkg::OFF_INTSET;
   assign wr_intclr = dp_wr && dp_addr == adcc_pkg::OFF_INTCLR;
   assign wr_enable = dp_wr && dp_addr == adcc_pkg::OFF_ENABLE;
   assign wr_config = dp_wr && dp_addr == adcc_pkg::OFF_CONFIG;

   // Read mux; unmapped and task offsets read zero
   always_comb begin
      o_hrdata = 32'h0000_0000;
      if (dp_rd) begin
         unique case (dp_addr)
            adcc_pkg::OFF_DONE: o_hrdata[0] = done_flag;
            adcc_pkg::OFF_INTERRUPT_ENABLE, adcc_pkg::OFF_INTSET,
            adcc_pkg::OFF_INTCLR: o_hrdata[0] = interrupt_enable;
            adcc_pkg::OFF_BUSY: o_hrdata[0] = (state != adcc_pkg::ADCC_OFF);
            adcc_pkg::OFF_ENABLE: o_hrdata[0] = enable;
            adcc_pkg::OFF_CONFIG: o_hrdata = config_q;
            adcc_pkg::OFF_RESULT: o_hrdata[adcc_pkg::RESULT_W-1:0] = result;
            default: o_hrdata = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   // Interrupt enable with set and clear aliases
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         interrupt_enable <= 1'b0;
      end else if (wr_interrupt_enable) begin
         interrupt_enable <= i_hwdata[0];
      end else if (wr_intset && i_hwdata[0]) begin
         interrupt_enable <= 1'b1;
      end else if (wr_intclr && i_hwdata[0]) begin
         interrupt_enable <= 1'b0;
      end
   end

   // Enable and configuration
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         enable <= 1'b0;
         config_q <= adcc_pkg::CONFIG_RESET;
      end else begin
         if (wr_enable) begin
            enable <= i_hwdata[0];
         end
         if (wr_config) begin
            config_q <= i_hwdata & adcc_pkg::CONFIG_MASK;
         end
      end
   end

   // Configuration fields to the analog section
   assign o_cfg.res = config_q[adcc_pkg::RES_LSB +: 2];
   assign o_cfg.inpsel = config_q[adcc_pkg::INPSEL_LSB +: 3];
   assign o_cfg.refsel = config_q[adcc_pkg::REFSEL_LSB +: 2];
   assign o_cfg.psel = config_q[adcc_pkg::PSEL_LSB +: 8];
   assign o_cfg.extref = config_q[adcc_pkg::EXTREF_LSB +: 2];

   // One-hot pin select to pin index
   always_comb begin
      pin_valid = 1'b0;
      pin_enc = 3'h0;
      for (int k = 0; k < 8; k++) begin
         if (o_cfg.psel == 8'(1 << k)) begin
            pin_valid = 1'b1;
            pin_enc = 3'(k);
         end
      end
   end

   assign o_pin_claim = enable && pin_valid;
   assign o_pin_index = pin_enc;

   // ----------------------------------------------------------------
   // Conversion sequencer
   // ----------------------------------------------------------------
   // Sample synchroniser from the analog domain
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         sample_s1 <= '0;
         sample_s2 <= '0;
      end else begin
         sample_s1 <= i_sample;
         sample_s2 <= sample_s1;
      end
   end

   assign start_req = enable && (wr_start || i_start_trig);
   assign stop_req = wr_stop || i_stop_trig;

   always_comb begin
      unique case (o_cfg.res)
         adcc_pkg::RES_8BIT: conv_len = 16'(CONV8_CYCLES);
         adcc_pkg::RES_9BIT: conv_len = 16'(CONV9_CYCLES);
         default: conv_len = 16'(CONV10_CYCLES);
      endcase
   end

   // State and cycle count
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         state <= adcc_pkg::ADCC_OFF;
         count <= '0;
      end else if (stop_req || !enable) begin
         state <= adcc_pkg::ADCC_OFF;
         count <= '0;
      end else begin
         unique case (state)
            adcc_pkg::ADCC_OFF: begin
               if (start_req) begin
                  state <= adcc_pkg::ADCC_CONVERT;
                  count <= conv_len - 16'h0001;
               end
            end
            adcc_pkg::ADCC_CONVERT: begin
               if (count == 16'h0000) begin
                  state <= adcc_pkg::ADCC_STORE;
               end else begin
                  count <= count - 16'h0001;
               end
            end
            adcc_pkg::ADCC_STORE: state <= adcc_pkg::ADCC_OFF;
         endcase
      end
   end

   assign finish = state == adcc_pkg::ADCC_STORE && !stop_req && enable;
   assign o_analog_power = state != adcc_pkg::ADCC_OFF;

   // Saturate and right-justify the sample to the chosen width
   always_comb begin
      next_result = '1;
      unique case (o_cfg.res)
         adcc_pkg::RES_8BIT: begin
            if (sample_s2 < SAMPLE_W'(256)) begin
               next_result = adcc_pkg::RESULT_W'(sample_s2);
            end else begin
               next_result = adcc_pkg::RESULT_W'(255);
            end
         end
         adcc_pkg::RES_9BIT: begin
            if (sample_s2 < SAMPLE_W'(512)) begin
               next_result = adcc_pkg::RESULT_W'(sample_s2);
            end else begin
               next_result = adcc_pkg::RESULT_W'(511);
            end
         end
         default: begin
            if (sample_s2 < SAMPLE_W'(1024)) begin
               next_result = adcc_pkg::RESULT_W'(sample_s2);
            end else begin
               next_result = '1;
            end
         end
      endcase
   end

   // Result store and done event
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         result <= '0;
         o_done_event <= 1'b0;
      end else begin
         o_done_event <= finish;
         if (finish) begin
            result <= next_result;
         end
      end
   end

   // Sticky done flag; set wins over software clear
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         done_flag <= 1'b0;
      end else if (finish) begin
         done_flag <= 1'b1;
      end else if (wr_done) begin
         done_flag <= i_hwdata[0];
      end
   end

   assign o_irq = interrupt_enable && done_flag;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence start_seq;
      state == adcc_pkg::ADCC_OFF && start_req && !stop_req;
   endsequence

   busy_after_start_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      start_seq |=> o_analog_power)
      else $error("start did not begin conversion");

   busy_reads_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      dp_rd && dp_addr == adcc_pkg::OFF_BUSY |-> o_hrdata[0] == o_analog_power)
      else $error("busy read mismatch");

   done_loads_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      finish |=> o_done_event && result == $past(next_result))
      else $error("done without result");

   power_down_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      o_done_event |-> !o_analog_power)
      else $error("analog still on after done");

   one_shot_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      $fell(o_analog_power) && !start_req |=> !o_analog_power)
      else $error("conversion restarted by itself");

   pin_claim_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      !enable |-> !o_pin_claim)
      else $error("pin claimed while disabled");

   set_enables_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      wr_intset && i_hwdata[0] && !wr_interrupt_enable |=> interrupt_enable)
      else $error("interrupt set failed");

   clr_disables_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      wr_intclr && i_hwdata[0] && !wr_interrupt_enable && !wr_intset |=> !interrupt_enable)
      else $error("interrupt clear failed");

   zero_no_effect_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (wr_intset || wr_intclr) && !i_hwdata[0] |=> $stable(interrupt_enable))
      else $error("zero write changed enable");

   irq_gate_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      !interrupt_enable |-> !o_irq)
      else $error("interrupt while masked");

   saturate_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      finish && o_cfg.res == adcc_pkg::RES_10BIT && sample_s2 >= SAMPLE_W'(1024)
      |=> result == '1)
      else $error("no saturation");

   stop_abort_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      stop_req |=> !o_analog_power ##1 !o_done_event)
      else $error("stop did not abort");
endmodule

// >>> testbench/adcc_pin_model.sv
// Analog input pin model that feeds sample codes to the converter
module adcc_pin_model (
   // Clock
   input wire logic i_mclk,
   // Pin control from the converter
   input wire logic i_claim,
   // Level chosen by the bench
   input wire logic [11:0] i_level,
   // Code seen by the converter
   output logic [11:0] o_sample
);
   timeunit 1ns;
   timeprecision 1ps;

   // Unclaimed pin gives a code that changes every cycle, never a stale level
   initial o_sample = 12'h000;
   always @(posedge i_mclk) begin
      if (i_claim) o_sample <= i_level;
      else o_sample <= ~o_sample;
   end
endmodule

// >>> testbench/adcc_top_test.sv
// Self-checking bench for the converter control block
module adcc_top_test;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // Signals and instances
   // ----------------------------------------------------------------
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic start_trig = 1'b0;
   logic stop_trig = 1'b0;
   logic [11:0] level = 12'h000;
   logic [11:0] sample;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic hready, hresp, done_ev, irq, power, claim;
   logic [2:0] pin_idx;
   adcc_pkg::adcc_cfg_t cfg;
   int fail_count = 0;
   int total_checks = 0;
   int cycles = 0;

   adcc_top #(.CONV8_CYCLES(4), .CONV9_CYCLES(6), .CONV10_CYCLES(8)) dut_u (
      .i_mclk(mclk), .i_rst(rst), .i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
      .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
      .i_start_trig(start_trig), .i_stop_trig(stop_trig), .o_done_event(done_ev),
      .o_irq(irq), .i_sample(sample), .o_analog_power(power), .o_pin_claim(claim),
      .o_pin_index(pin_idx), .o_cfg(cfg));

   adcc_pin_model pin_u (.i_mclk(mclk), .i_claim(claim), .i_level(level), .o_sample(sample));

   // Clock and hang guard
   always #20 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         test_done;
      end
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
         fail_count++;
      end
   endtask

   // One AHB-Lite single word transfer; read data lands in rd
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
      htrans <= 2'h2;
      haddr <= {20'h0, a};
      hwrite <= w;
      do @(posedge mclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      // Read data is taken at the edge that ends the data phase
      do @(posedge mclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(nm, exp, rd);
      chk("hresp", 32'h0, 32'(hresp));
   endtask

   // Counts done pulses over a window and notes power at each pulse
   task automatic wait_done(output int n, output logic pw);
      n = 0;
      pw = 1'b0;
      for (int i = 0; i < 30; i++) begin
         @(negedge mclk);
         if (done_ev === 1'b1) begin
            n++;
            pw = power;
         end
         @(posedge mclk);
      end
   endtask

   // One-cycle pulse on the stop trigger when stop is set, else on the start trigger
   task automatic pulse(input logic stop);
      if (stop) begin
         stop_trig <= 1'b1;
      end else begin
         start_trig <= 1'b1;
      end
      @(posedge mclk);
      if (stop) begin
         stop_trig <= 1'b0;
      end else begin
         start_trig <= 1'b0;
      end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      rchk("interrupt_enable", adcc_pkg::OFF_INTERRUPT_ENABLE, 32'h0);
      rchk("intset", adcc_pkg::OFF_INTSET, 32'h0);
      rchk("intclr", adcc_pkg::OFF_INTCLR, 32'h0);
      rchk("enable", adcc_pkg::OFF_ENABLE, 32'h0);
      rchk("config", adcc_pkg::OFF_CONFIG, adcc_pkg::CONFIG_RESET);
      rchk("unmapped", 12'h600, 32'h0);
      wr(adcc_pkg::OFF_START, 32'h1);
      rchk("busy off", adcc_pkg::OFF_BUSY, 32'h0);
      @(negedge mclk);
      chk("claim off", 32'h0, 32'(claim));
      chk("power off", 32'h0, 32'(power));
      @(posedge mclk);
   endtask

   task automatic t_pins;
      wr(adcc_pkg::OFF_ENABLE, 32'h1);
      for (int i = 0; i < 8; i++) begin
         wr(adcc_pkg::OFF_CONFIG, 32'h100 << i);
         @(negedge mclk);
         chk("pin index", 32'(i), 32'(pin_idx));
         chk("claim", 32'h1, 32'(claim));
         @(posedge mclk);
      end
      wr(adcc_pkg::OFF_CONFIG, 32'hfffc_0880);
      rchk("config mask", adcc_pkg::OFF_CONFIG, 32'h0000_0800);
      chk("cfg psel", 32'h8, 32'(cfg.psel));
      wr(adcc_pkg::OFF_CONFIG, 32'h0002_0854);
      @(negedge mclk);
      chk("cfg inpsel", 32'h5, 32'(cfg.inpsel));
      chk("cfg refsel", 32'h2, 32'(cfg.refsel));
      chk("cfg extref", 32'h2, 32'(cfg.extref));
      @(posedge mclk);
   endtask

   task automatic t_conv(input logic [1:0] r, input logic [11:0] lv, input logic [31:0] exp);
      int n;
      logic pw;
      level <= lv;
      wr(adcc_pkg::OFF_CONFIG, 32'h800 | 32'(r));
      @(negedge mclk);
      chk("cfg res", 32'(r), 32'(cfg.res));
      @(posedge mclk);
      wr(adcc_pkg::OFF_START, 32'h1);
      rchk("busy", adcc_pkg::OFF_BUSY, 32'h1);
      wait_done(n, pw);
      chk("done count", 32'h1, 32'(n));
      chk("power at done", 32'h0, 32'(pw));
      rchk("ready", adcc_pkg::OFF_BUSY, 32'h0);
      rchk("result", adcc_pkg::OFF_RESULT, exp);
      rchk("done flag", adcc_pkg::OFF_DONE, 32'h1);
   endtask

   task automatic t_irq;
      @(negedge mclk);
      chk("irq masked", 32'h0, 32'(irq));
      @(posedge mclk);
      wr(adcc_pkg::OFF_INTSET, 32'h0);
      rchk("set zero", adcc_pkg::OFF_INTERRUPT_ENABLE, 32'h0);
      wr(adcc_pkg::OFF_INTSET, 32'h1);
      rchk("set one", adcc_pkg::OFF_INTSET, 32'h1);
      chk("irq on", 32'h1, 32'(irq));
      wr(adcc_pkg::OFF_INTCLR, 32'h0);
      rchk("clr zero", adcc_pkg::OFF_INTCLR, 32'h1);
      wr(adcc_pkg::OFF_INTCLR, 32'h1);
      rchk("clr one", adcc_pkg::OFF_INTERRUPT_ENABLE, 32'h0);
      chk("irq off", 32'h0, 32'(irq));
      wr(adcc_pkg::OFF_INTERRUPT_ENABLE, 32'h1);
      wr(adcc_pkg::OFF_DONE, 32'h0);
      rchk("flag clear", adcc_pkg::OFF_DONE, 32'h0);
      chk("irq idle", 32'h0, 32'(irq));
      wr(adcc_pkg::OFF_RESULT, 32'h0);
      rchk("result ro", adcc_pkg::OFF_RESULT, 32'h3ff);
   endtask

   task automatic t_trig;
      int n;
      logic pw;
      for (int k = 0; k < 3; k++) begin
         level <= 12'h011 * 12'(k + 1);
         pulse(1'b0);
         repeat (2) @(posedge mclk);
         pulse(1'b0);
         wait_done(n, pw);
         chk("one shot", 32'h1, 32'(n));
         rchk("trig result", adcc_pkg::OFF_RESULT, 32'h011 * 32'(k + 1));
      end
      rchk("irq flag", adcc_pkg::OFF_DONE, 32'h1);
      chk("irq raised", 32'h1, 32'(irq));
      wr(adcc_pkg::OFF_DONE, 32'h0);
   endtask

   task automatic t_stop;
      int n;
      logic pw;
      wr(adcc_pkg::OFF_START, 32'h1);
      wr(adcc_pkg::OFF_STOP, 32'h1);
      rchk("stop busy", adcc_pkg::OFF_BUSY, 32'h0);
      chk("stop power", 32'h0, 32'(power));
      wait_done(n, pw);
      chk("stop no done", 32'h0, 32'(n));
      pulse(1'b0);
      pulse(1'b1);
      wait_done(n, pw);
      chk("trig stop", 32'h0, 32'(n));
      rchk("no flag", adcc_pkg::OFF_DONE, 32'h0);
      // Disabling aborts a conversion and releases the pin
      wr(adcc_pkg::OFF_START, 32'h1);
      wr(adcc_pkg::OFF_ENABLE, 32'h0);
      rchk("disable abort", adcc_pkg::OFF_BUSY, 32'h0);
      chk("claim released", 32'h0, 32'(claim));
      wr(adcc_pkg::OFF_START, 32'h1);
      rchk("start disabled", adcc_pkg::OFF_BUSY, 32'h0);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      t_reset;
      t_pins;
      t_conv(2'h0, 12'h05a, 32'h05a);
      t_conv(2'h0, 12'hfff, 32'h0ff);
      t_conv(2'h1, 12'h1a3, 32'h1a3);
      t_conv(2'h1, 12'h200, 32'h1ff);
      t_conv(2'h2, 12'h2c5, 32'h2c5);
      t_conv(2'h2, 12'hc00, 32'h3ff);
      t_irq;
      t_trig;
      t_stop;
      test_done;
   end
endmodule
